// *** rtl/optical_module_control_status.sv ***
`default_nettype none
module optical_module_control_status (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // Host low-speed pins
    input wire logic select_n_i,
    input wire logic laser_off_request_i,
    input wire logic power_down_i,
    // Management decode: loopback command and status read strobe
    input wire logic mgmt_cmd_valid_i,
    input wire logic [1:0] mgmt_loop_mode_i,
    input wire logic mgmt_status_read_i,
    output logic mgmt_ack_o,
    output logic [4:0] mgmt_status_o,
    input wire logic [1:0] line_rate_i,
    // Analog front-end status
    input wire logic tx_pll_locked_i,
    input wire logic rx_cdr_locked_i,
    input wire logic rx_signal_detect_i,
    input wire logic rx_power_ok_i,
    // Host-side transmit stream in, host-side receive stream out
    input wire logic host_tx_valid_i,
    output logic host_tx_ready_o,
    input wire logic [15:0] host_tx_data_i,
    output logic host_rx_valid_o,
    input wire logic host_rx_ready_i,
    output logic [15:0] host_rx_data_o,
    // Line-side receive stream in, line-side transmit stream out
    input wire logic line_rx_valid_i,
    input wire logic [15:0] line_rx_data_i,
    output logic line_tx_valid_o,
    input wire logic line_tx_ready_i,
    output logic [15:0] line_tx_data_o,
    // Status pins
    output logic module_not_ready_o,
    output logic interrupt_n_o,
    output logic receive_signal_lost_o,
    output logic laser_enable_o,
    output logic module_absent_o,
    output logic pll_reset_o,
    output logic [1:0] pll_rate_o
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [2:0] sel_sync;
        logic [2:0] dis_sync;
        logic [2:0] pdn_sync;
        optical_ctrl_pkg::loop_mode_t loop_mode;
        optical_ctrl_pkg::power_state_t pwr;
        logic [7:0] relock_cnt;
        optical_ctrl_pkg::line_status_t status;
        logic not_ready;
        logic irq_n;
        logic los;
        logic laser_en;
        logic absent;
        logic pll_rst;
        logic [1:0] rate;
        logic ack;
        logic [4:0] mgmt_status;
        optical_ctrl_pkg::beat_t host_rx;
        optical_ctrl_pkg::beat_t line_tx;
    } ctrl_state_t;

    ctrl_state_t state_r;
    ctrl_state_t state_nxt;

    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [15:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [15:0] fifo_out_data;
    logic selected;
    logic laser_off;
    logic pdn_level;
    logic pdn_fall;
    logic blank;
    logic host_rx_free;
    logic line_tx_free;

    function automatic logic beat_free(input optical_ctrl_pkg::beat_t b, input logic ready);
        beat_free = !b.valid || ready;
    endfunction : beat_free

    // Only stage 1 onward is read; stage 0 feeds stage 1 alone
    assign selected = !state_r.sel_sync[1];
    assign laser_off = state_r.dis_sync[1];
    assign pdn_level = state_r.pdn_sync[1];
    assign pdn_fall = state_r.pdn_sync[2] && !state_r.pdn_sync[1];
    assign blank = pdn_level || (state_r.pwr != optical_ctrl_pkg::PWR_RUN);
    assign host_rx_free = beat_free(state_r.host_rx, host_rx_ready_i);
    assign line_tx_free = beat_free(state_r.line_tx, line_tx_ready_i);

    // ==========================================================
    // Data path routing
    // Host transmit data goes through the FIFO; its exit lands on line or,
    // in system loopback, back toward the host. Line data in network
    // loopback bypasses the FIFO since the line source cannot be stalled.
    assign fifo_in_valid = host_tx_valid_i && !blank;
    assign fifo_in_data = host_tx_data_i;
    assign host_tx_ready_o = fifo_in_ready && !blank && clk_en_i;
    assign fifo_out_ready = clk_en_i && !blank
        && ((state_r.loop_mode == optical_ctrl_pkg::LOOP_SYSTEM) ? host_rx_free : line_tx_free);

    beat_fifo #(
        .WIDTH(optical_ctrl_pkg::DATA_W),
        .DEPTH(optical_ctrl_pkg::FIFO_DEPTH),
        .AW(optical_ctrl_pkg::FIFO_AW)
    ) u_fifo (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .enable_i(clk_en_i),
        .flush_i(blank),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // ==========================================================
    // Next state
    always_comb begin
        state_nxt = state_r;
        state_nxt.sel_sync = {state_r.sel_sync[1:0], select_n_i};
        state_nxt.dis_sync = {state_r.dis_sync[1:0], laser_off_request_i};
        state_nxt.pdn_sync = {state_r.pdn_sync[1:0], power_down_i};

        // Management: commands and reads are only honoured while selected
        state_nxt.ack = 1'b0;
        if (selected && (mgmt_cmd_valid_i || mgmt_status_read_i)) begin
            state_nxt.ack = 1'b1;
        end
        if (selected && mgmt_cmd_valid_i) begin
            unique case (mgmt_loop_mode_i)
                2'h1: state_nxt.loop_mode = optical_ctrl_pkg::LOOP_SYSTEM;
                2'h3: state_nxt.loop_mode = optical_ctrl_pkg::LOOP_NETWORK;
                default: state_nxt.loop_mode = optical_ctrl_pkg::LOOP_NONE;
            endcase
        end

        // Power sequence
        unique case (state_r.pwr)
            optical_ctrl_pkg::PWR_RUN: begin
                if (pdn_level) begin
                    state_nxt.pwr = optical_ctrl_pkg::PWR_DOWN;
                end
            end
            optical_ctrl_pkg::PWR_DOWN: begin
                if (pdn_fall) begin
                    state_nxt.pwr = optical_ctrl_pkg::PWR_RELOCK;
                    state_nxt.relock_cnt = optical_ctrl_pkg::COUNT_RESET;
                end
            end
            optical_ctrl_pkg::PWR_RELOCK: begin
                if (pdn_level) begin
                    state_nxt.pwr = optical_ctrl_pkg::PWR_DOWN;
                end else if (state_r.relock_cnt < optical_ctrl_pkg::RELOCK_CYC_8) begin
                    state_nxt.relock_cnt = state_r.relock_cnt + 8'h01;
                end else if (tx_pll_locked_i && rx_cdr_locked_i) begin
                    state_nxt.pwr = optical_ctrl_pkg::PWR_RUN;
                end
            end
            default: state_nxt.pwr = optical_ctrl_pkg::PWR_DOWN;
        endcase
        // PLL held in reset for the single cycle of the falling edge
        state_nxt.pll_rst = pdn_fall;
        state_nxt.rate = line_rate_i;

        // Status gathering
        state_nxt.status.pll_locked = tx_pll_locked_i;
        state_nxt.status.cdr_locked = rx_cdr_locked_i;
        state_nxt.status.signal_lost = !rx_signal_detect_i;
        state_nxt.status.optical_power_low = !rx_power_ok_i;
        state_nxt.status.fault = !tx_pll_locked_i || !rx_cdr_locked_i || !rx_signal_detect_i
            || (state_nxt.pwr != optical_ctrl_pkg::PWR_RUN) || pdn_level;
        state_nxt.not_ready = state_nxt.status.fault;
        state_nxt.irq_n = !(state_nxt.status.fault || !rx_power_ok_i);
        state_nxt.los = !rx_power_ok_i;
        state_nxt.laser_en = !laser_off && !pdn_level;
        state_nxt.absent = 1'b0;
        if (selected && mgmt_status_read_i) begin
            state_nxt.mgmt_status = state_r.status;
        end

        // Output stages
        if (host_rx_free) begin
            state_nxt.host_rx.valid = 1'b0;
        end
        if (line_tx_free) begin
            state_nxt.line_tx.valid = 1'b0;
        end
        if (fifo_out_valid && fifo_out_ready) begin
            if (state_r.loop_mode == optical_ctrl_pkg::LOOP_SYSTEM) begin
                state_nxt.host_rx = '{valid: 1'b1, data: fifo_out_data};
            end else begin
                state_nxt.line_tx = '{valid: 1'b1, data: fifo_out_data};
            end
        end
        if (line_rx_valid_i && !blank) begin
            if (state_r.loop_mode == optical_ctrl_pkg::LOOP_NETWORK) begin
                // Line beats have no stall; a busy stage drops the beat
                if (line_tx_free && !(fifo_out_valid && fifo_out_ready)) begin
                    state_nxt.line_tx = '{valid: 1'b1, data: line_rx_data_i};
                end
            end else if (state_r.loop_mode == optical_ctrl_pkg::LOOP_NONE && host_rx_free) begin
                state_nxt.host_rx = '{valid: 1'b1, data: line_rx_data_i};
            end
        end
        if (blank) begin
            state_nxt.host_rx.valid = 1'b0;
            state_nxt.line_tx.valid = 1'b0;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= '0;
            // Synchronisers start idle: deselected, so no false select follows reset
            state_r.sel_sync <= ~optical_ctrl_pkg::SYNC_RESET;
            state_r.dis_sync <= optical_ctrl_pkg::SYNC_RESET;
            state_r.pdn_sync <= optical_ctrl_pkg::SYNC_RESET;
            state_r.pwr <= optical_ctrl_pkg::PWR_RELOCK;
            state_r.relock_cnt <= optical_ctrl_pkg::COUNT_RESET;
            state_r.not_ready <= 1'b1;
            state_r.irq_n <= 1'b1;
        end else if (clk_en_i) begin
            state_r <= state_nxt;
        end
    end

    assign mgmt_ack_o = state_r.ack;
    assign mgmt_status_o = state_r.mgmt_status;
    assign module_not_ready_o = state_r.not_ready;
    assign interrupt_n_o = state_r.irq_n;
    assign receive_signal_lost_o = state_r.los;
    assign laser_enable_o = state_r.laser_en;
    assign module_absent_o = state_r.absent;
    assign pll_reset_o = state_r.pll_rst;
    assign pll_rate_o = state_r.rate;
    assign host_rx_valid_o = state_r.host_rx.valid;
    assign host_rx_data_o = state_r.host_rx.data;
    assign line_tx_valid_o = state_r.line_tx.valid;
    assign line_tx_data_o = state_r.line_tx.data;

endmodule : optical_module_control_status
`default_nettype wire

// *** rtl/optical_ctrl_pkg.sv ***
`default_nettype none
package optical_ctrl_pkg;

    // ==========================================================
    // Widths and sizes
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 20;
    // Least settle time after the reset pulse before lock is trusted again
    localparam int RELOCK_NS = 1000;
    localparam int RELOCK_CYC = (RELOCK_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] RELOCK_CYC_8 = 8'(RELOCK_CYC);
    localparam logic [7:0] COUNT_RESET = 8'h00;

    // ==========================================================
    // Modes
    typedef enum logic [1:0] {
        LOOP_NONE = 2'h0,
        LOOP_SYSTEM = 2'h1,
        LOOP_NETWORK = 2'h3
    } loop_mode_t;

    // Four serial rates judged against the reference clock
    typedef enum logic [1:0] {
        RATE_9G95 = 2'h0,
        RATE_10G3 = 2'h1,
        RATE_10G5 = 2'h3,
        RATE_10G75 = 2'h2
    } line_rate_t;

    typedef enum logic [1:0] {
        PWR_RUN = 2'h0,
        PWR_DOWN = 2'h1,
        PWR_RELOCK = 2'h3
    } power_state_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic pll_locked;
        logic cdr_locked;
        logic signal_lost;
        logic optical_power_low;
        logic fault;
    } line_status_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } beat_t;

    localparam logic [2:0] SYNC_RESET = 3'h0;

endpackage : optical_ctrl_pkg
`default_nettype wire

// *** rtl/beat_fifo.sv ***
`default_nettype none
module beat_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } fifo_state_t;

    fifo_state_t state_r;
    fifo_state_t state_nxt;
    logic push;
    logic pop;

    assign in_ready_o = (state_r.count != (AW+1)'(DEPTH));
    assign out_valid_o = (state_r.count != '0);
    assign out_data_o = state_r.mem[state_r.rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        state_nxt = state_r;
        if (push) begin
            state_nxt.mem[state_r.wr_ptr] = in_data_i;
            state_nxt.wr_ptr = state_r.wr_ptr + AW'(1);
        end
        if (pop) begin
            state_nxt.rd_ptr = state_r.rd_ptr + AW'(1);
        end
        state_nxt.count = state_r.count + (AW+1)'(push) - (AW+1)'(pop);
        // Flush drops everything, used when power-down blanks the path
        if (flush_i) begin
            state_nxt.wr_ptr = '0;
            state_nxt.rd_ptr = '0;
            state_nxt.count = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= '0;
        end else if (enable_i) begin
            state_r <= state_nxt;
        end
    end

endmodule : beat_fifo
`default_nettype wire

// *** tb/optical_ctrl_asserts.sv ***
`default_nettype none
module optical_ctrl_asserts (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic select_n_i,
    input wire logic laser_off_request_i,
    input wire logic power_down_i,
    input wire logic mgmt_cmd_valid_i,
    input wire logic mgmt_status_read_i,
    input wire logic mgmt_ack_o,
    input wire logic tx_pll_locked_i,
    input wire logic rx_cdr_locked_i,
    input wire logic rx_power_ok_i,
    input wire logic host_tx_ready_o,
    input wire logic module_not_ready_o,
    input wire logic interrupt_n_o,
    input wire logic receive_signal_lost_o,
    input wire logic laser_enable_o,
    input wire logic module_absent_o,
    input wire logic pll_reset_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // ==========================================================
    // Management and status pins
    // Select passes two sync stages, so an ack looks three edges back
    chk_ack_selected: assert property (mgmt_ack_o |-> !$past(select_n_i, 3))
        else $error("ack while deselected");
    chk_ack_cause: assert property (mgmt_ack_o |-> $past(mgmt_cmd_valid_i) || $past(mgmt_status_read_i))
        else $error("ack without request");
    chk_nr_txpll: assert property (!tx_pll_locked_i |-> ##[1:3] module_not_ready_o)
        else $error("tx unlock not flagged");
    chk_nr_cdr: assert property (!rx_cdr_locked_i |-> ##[1:3] module_not_ready_o)
        else $error("cdr unlock not flagged");
    chk_los_power: assert property (!reset_i |=> receive_signal_lost_o == !$past(rx_power_ok_i))
        else $error("loss of signal wrong");
    chk_irq_power: assert property (!rx_power_ok_i [*3] |=> !interrupt_n_o)
        else $error("interrupt not low");
    chk_laser_off: assert property (laser_off_request_i [*3] |=> !laser_enable_o)
        else $error("laser still on");
    chk_absent_low: assert property (module_absent_o == 1'h0)
        else $error("absent pin high");
    // ==========================================================
    // Power-down and relock
    chk_down_blank: assert property (power_down_i [*3] |=> !host_tx_ready_o && module_not_ready_o)
        else $error("not blanked in power down");
    chk_reset_edge: assert property ($fell(power_down_i) |-> ##[1:5] pll_reset_o)
        else $error("no reset pulse on fall");
    chk_reset_pulse: assert property (pll_reset_o |=> !pll_reset_o)
        else $error("reset pulse too long");
    chk_relock_hold: assert property ($rose(pll_reset_o) |-> module_not_ready_o [*8])
        else $error("ready before relock");
    cover property (mgmt_ack_o);
    cover property ($rose(pll_reset_o));
    cover property ($fell(interrupt_n_o));
endmodule : optical_ctrl_asserts
bind optical_module_control_status optical_ctrl_asserts u_chk (
    .clk_i(clk_i), .reset_i(reset_i), .select_n_i(select_n_i), .laser_off_request_i(laser_off_request_i),
    .power_down_i(power_down_i), .mgmt_cmd_valid_i(mgmt_cmd_valid_i), .mgmt_status_read_i(mgmt_status_read_i),
    .mgmt_ack_o(mgmt_ack_o), .tx_pll_locked_i(tx_pll_locked_i), .rx_cdr_locked_i(rx_cdr_locked_i),
    .rx_power_ok_i(rx_power_ok_i), .host_tx_ready_o(host_tx_ready_o), .module_not_ready_o(module_not_ready_o),
    .interrupt_n_o(interrupt_n_o), .receive_signal_lost_o(receive_signal_lost_o),
    .laser_enable_o(laser_enable_o), .module_absent_o(module_absent_o), .pll_reset_o(pll_reset_o));
`default_nettype wire

// *** tb/host_side_peer.sv ***
`default_nettype none
module host_side_peer (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic stall_i,
    input wire logic slow_i,
    input wire logic rx_valid_i,
    input wire logic [15:0] rx_data_i,
    input wire logic tx_valid_i,
    input wire logic [15:0] tx_data_i,
    output logic rx_ready_o,
    output logic tx_ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] rx_q[$];
    logic [15:0] tx_q[$];
    logic phase_r = 1'h0;
    // Slow mode takes a beat only every other cycle
    assign rx_ready_o = !stall_i && !reset_i && (!slow_i || phase_r);
    assign tx_ready_o = rx_ready_o;
    always @(posedge clk_i) begin
        phase_r <= !phase_r;
        if (rx_valid_i && rx_ready_o) rx_q.push_back(rx_data_i);
        if (tx_valid_i && tx_ready_o) tx_q.push_back(tx_data_i);
    end
endmodule : host_side_peer
`default_nettype wire

// *** tb/optical_module_control_status_tb.sv ***
`default_nettype none
module optical_module_control_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'h0, reset_i = 1'h1, sel_n = 1'h1, laser_off = 1'h0, pwr_dn = 1'h0, cmd = 1'h0, rd = 1'h0;
    logic pll_ok = 1'h1, cdr_ok = 1'h1, sig_ok = 1'h1, pwr_ok = 1'h1, htx_v = 1'h0, lrx_v = 1'h0;
    logic stall = 1'h0, slow = 1'h0, ack, htx_rdy, hrx_v, hrx_rdy, ltx_v, ltx_rdy, nr, irq_n, los, laser_en;
    logic absent, pll_rst, ok, a, en = 1'h1;
    logic [1:0] mode = 2'h0, rate = 2'h0, pll_rate;
    logic [4:0] status;
    logic [15:0] htx_d = 16'h0000, lrx_d = 16'h0000, hrx_d, ltx_d;
    int num_errors = 0, checked = 0, cycles = 0, n;
    optical_module_control_status uut (
        .clk_i(clk_i), .reset_i(reset_i), .clk_en_i(en), .select_n_i(sel_n), .laser_off_request_i(laser_off),
        .power_down_i(pwr_dn), .mgmt_cmd_valid_i(cmd), .mgmt_loop_mode_i(mode), .mgmt_status_read_i(rd),
        .mgmt_ack_o(ack), .mgmt_status_o(status), .line_rate_i(rate), .tx_pll_locked_i(pll_ok),
        .rx_cdr_locked_i(cdr_ok), .rx_signal_detect_i(sig_ok), .rx_power_ok_i(pwr_ok), .host_tx_valid_i(htx_v),
        .host_tx_ready_o(htx_rdy), .host_tx_data_i(htx_d), .host_rx_valid_o(hrx_v), .host_rx_ready_i(hrx_rdy),
        .host_rx_data_o(hrx_d), .line_rx_valid_i(lrx_v), .line_rx_data_i(lrx_d), .line_tx_valid_o(ltx_v),
        .line_tx_ready_i(ltx_rdy), .line_tx_data_o(ltx_d), .module_not_ready_o(nr), .interrupt_n_o(irq_n),
        .receive_signal_lost_o(los), .laser_enable_o(laser_en), .module_absent_o(absent),
        .pll_reset_o(pll_rst), .pll_rate_o(pll_rate));
    host_side_peer peer (
        .clk_i(clk_i), .reset_i(reset_i), .stall_i(stall), .slow_i(slow), .rx_valid_i(hrx_v), .rx_data_i(hrx_d),
        .tx_valid_i(ltx_v), .tx_data_i(ltx_d), .rx_ready_o(hrx_rdy), .tx_ready_o(ltx_rdy));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            stop_test();
        end
    end
    // ==========================================================
    // Access tasks
    task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_word
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        cmp_word(what, {15'h0, exp}, {15'h0, got});
    endtask : cmp_bit
    task automatic tick(input int k);
        repeat (k) @(negedge clk_i);
    endtask : tick
    // Ack may land at either of the two edges that follow the strobe
    task automatic mgmt(input logic c, input logic [1:0] m, input logic r, output logic got);
        cmd = c;
        mode = m;
        rd = r;
        @(negedge clk_i);
        cmd = 1'h0;
        rd = 1'h0;
        got = ack;
        @(negedge clk_i);
        got = got | ack;
    endtask : mgmt
    // A refused beat stays offered; the caller retries with the same word
    task automatic push(input logic [15:0] d, output logic took);
        int k;
        k = 0;
        htx_v = 1'h1;
        htx_d = d;
        do begin
            took = htx_rdy;
            @(negedge clk_i);
            k++;
        end while (!took && k < 8);
        if (took) begin
            htx_v = 1'h0;
            htx_d = ~d;
        end
    endtask : push
    task automatic stop_test();
        $display("Counts: %0d checked, %0d mismatches", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    // ==========================================================
    // Tests
    initial begin
        tick(8);
        reset_i = 1'h0;
        cmp_bit("nr_reset", 1'h1, nr);
        cmp_bit("irq_reset", 1'h1, irq_n);
        cmp_bit("absent", 1'h0, absent);
        tick(30);
        cmp_bit("nr_locked", 1'h0, nr);
        cmp_bit("laser_on", 1'h1, laser_en);
        for (int r = 0; r < 4; r++) begin
            rate = 2'(r);
            tick(2);
            cmp_word("rate", 16'(r), {14'h0, pll_rate});
        end
        // Enable low must freeze the registered rate copy
        en = 1'h0;
        rate = 2'h0;
        tick(3);
        cmp_word("rate_frozen", 16'h0003, {14'h0, pll_rate});
        en = 1'h1;
        tick(2);
        cmp_word("rate_thawed", 16'h0000, {14'h0, pll_rate});
        $display("test reset done");
        mgmt(1'h1, optical_ctrl_pkg::LOOP_SYSTEM, 1'h0, a);
        cmp_bit("ack_deselected", 1'h0, a);
        sel_n = 1'h0;
        tick(3);
        mgmt(1'h1, optical_ctrl_pkg::LOOP_SYSTEM, 1'h0, a);
        cmp_bit("ack_selected", 1'h1, a);
        push(16'h1234, ok);
        tick(4);
        cmp_word("system_loop", 16'h1234, peer.rx_q[0]);
        mgmt(1'h1, optical_ctrl_pkg::LOOP_NETWORK, 1'h0, a);
        peer.tx_q.delete();
        lrx_v = 1'h1;
        lrx_d = 16'h5a5a;
        tick(1);
        lrx_v = 1'h0;
        lrx_d = 16'ha5a5;
        tick(4);
        cmp_word("network_loop", 16'h5a5a, peer.tx_q[0]);
        $display("test loopback done");
        mgmt(1'h1, optical_ctrl_pkg::LOOP_NONE, 1'h0, a);
        peer.tx_q.delete();
        stall = 1'h1;
        n = 0;
        ok = 1'h1;
        while (ok && n < 24) begin
            push(16'h0100 + 16'(n), ok);
            n++;
        end
        cmp_bit("fifo_refused", 1'h1, n >= 17 && n <= 19);
        slow = 1'h1;
        stall = 1'h0;
        push(16'h0100 + 16'(n - 1), ok);
        tick(60);
        cmp_word("fifo_count", 16'(n), 16'(peer.tx_q.size()));
        foreach (peer.tx_q[i]) cmp_word("fifo_word", 16'h0100 + 16'(i), peer.tx_q[i]);
        $display("test fifo done");
        pll_ok = 1'h0;
        tick(4);
        cmp_bit("nr_tx_pll", 1'h1, nr);
        pll_ok = 1'h1;
        cdr_ok = 1'h0;
        tick(4);
        cmp_bit("nr_cdr", 1'h1, nr);
        cdr_ok = 1'h1;
        sig_ok = 1'h0;
        tick(4);
        cmp_bit("nr_signal", 1'h1, nr);
        sig_ok = 1'h1;
        pwr_ok = 1'h0;
        tick(4);
        cmp_bit("los_low_power", 1'h1, los);
        cmp_bit("irq_low_power", 1'h0, irq_n);
        mgmt(1'h0, optical_ctrl_pkg::LOOP_NONE, 1'h1, a);
        cmp_bit("status_low_power", 1'h1, status[1]);
        pwr_ok = 1'h1;
        laser_off = 1'h1;
        tick(5);
        cmp_bit("irq_clear", 1'h1, irq_n);
        cmp_bit("nr_clear", 1'h0, nr);
        cmp_bit("laser_off", 1'h0, laser_en);
        laser_off = 1'h0;
        $display("test status done");
        pwr_dn = 1'h1;
        tick(5);
        cmp_bit("tx_ready_down", 1'h0, htx_rdy);
        cmp_bit("rx_valid_down", 1'h0, hrx_v | ltx_v);
        cmp_bit("nr_down", 1'h1, nr);
        pwr_dn = 1'h0;
        n = 0;
        repeat (8) begin
            @(negedge clk_i);
            if (pll_rst === 1'h1) n++;
        end
        cmp_word("reset_pulses", 16'h0001, 16'(n));
        cmp_bit("nr_relock", 1'h1, nr);
        tick(30);
        cmp_bit("nr_relocked", 1'h0, nr);
        sel_n = 1'h1;
        tick(3);
        mgmt(1'h0, optical_ctrl_pkg::LOOP_NONE, 1'h1, a);
        cmp_bit("ack_released", 1'h0, a);
        $display("test power done");
        stop_test();
    end
endmodule : optical_module_control_status_tb
`default_nettype wire
